// *** hw/tmr_cc.sv ***
// Input capture front end and two compare units of a 16-bit timer.
// Assumes the counter, prescaler and pin mux sit outside; the timer
// clock arrives as a one-cycle tick, and all inputs are synchronous.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Comparator select routes comparator output to capture
// - Sampled like count pin; filter adds five cycles
// - Input frozen in capture-as-top modes
// - Port-driven pin level triggers capture normally
// - Filter output changes after four equal samples
// - Filter enabled by control bit, system clock
// - Each capture overwrites capture value
// - Equality sets match flag next tick
// - Flag requests interrupt; cleared by ack, one
// - Compare A may serve as counter top
// - PWM modes buffer; others write directly
// - Compare values CPU-written, read directly
// - High byte to holding, low loads all
// - Force applies action outside PWM modes, no flag, no reload
// - Counter write blocks next tick's matches
// - Counter written to top skips top match
// - Output state kept across mode changes
// - Action bits take effect at once
// - Capture copies counter and sets flag
// - Capture low read latches high byte
module tmr_cc
   import tmr_cc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [7:0]  dat_i,
   output logic      [7:0]  dat_o,
   input  wire logic        we_i,
   input  wire logic        sel_i,
   input  wire logic        stb_i,
   input  wire logic        cyc_i,
   output logic             ack_o,
   input  wire logic        capture_input_pin_i,
   input  wire logic        comparator_output_i,
   input  wire logic [15:0] counter_value_i,
   input  wire logic        counter_wr_i,
   input  wire logic        tick_i,
   input  wire logic        top_i,
   input  wire logic        bottom_i,
   input  wire logic [2:0]  irq_ack_i,
   output logic      [2:0]  irq_o,
   output logic             compare_output_state_a_o,
   output logic             compare_output_state_b_o,
   output logic             top_a_match_o,
   output logic      [3:0]  waveform_mode_sel_o,
   output logic      [15:0] compare_value_a_o,
   output logic      [15:0] capture_value_o
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [1:0]  act_a;
      logic [1:0]  act_b;
      logic [3:0]  wgm;
      logic        edge_sel;
      logic        filt_en;
      logic        cmp_sel;
      logic [2:0]  flags;
      logic [2:0]  irq_en;
      logic [7:0]  temp;
      logic [15:0] cap;
      logic [15:0] ocr_a;
      logic [15:0] ocr_b;
      logic [15:0] buf_a;
      logic [15:0] buf_b;
      logic        oc_a;
      logic        oc_b;
      logic        block;
      logic        smp;
      logic [3:0]  shf;
      logic        filt;
      logic        prev;
      logic        ack;
      logic [7:0]  rdat;
   } state_t;

   state_t s_q;
   state_t s_d;

   // ----------------------------------------
   // Mode helpers
   // ----------------------------------------
   function automatic logic is_pwm(input logic [3:0] m);
      is_pwm = (m != WGM_NORMAL) && (m != WGM_CTC_A)
               && (m != WGM_CTC_CAP) && (m != WGM_RSVD);
   endfunction : is_pwm

   function automatic logic cap_is_top(input logic [3:0] m);
      cap_is_top = (m == WGM_PFC_CAP) || (m == 4'hA)
                   || (m == WGM_CTC_CAP) || (m == 4'hE);
   endfunction : cap_is_top

   function automatic logic a_is_top(input logic [3:0] m);
      a_is_top = (m == WGM_CTC_A) || (m == WGM_PFC_A)
                 || (m == 4'hB) || (m == 4'hF);
   endfunction : a_is_top

   function automatic logic apply(input logic [1:0] act,
                                  input logic       cur);
      case (act_t'(act))
         ACT_TOGGLE: apply = ~cur;
         ACT_CLEAR:  apply = 1'b0;
         ACT_SET:    apply = 1'b1;
         default:    apply = cur;
      endcase
   endfunction : apply

   // ----------------------------------------
   // Combinational next state
   // ----------------------------------------
   logic        req;
   logic        wr;
   logic        rd;
   logic        raw_in;
   logic        lvl;
   logic        cap_evt;
   logic        eq_a;
   logic        eq_b;
   logic        hit_a;
   logic        hit_b;
   logic        pwm;
   logic        upd;
   logic [15:0] wword;

   always_comb begin
      s_d   = s_q;
      req   = cyc_i && stb_i && !s_q.ack;
      wr    = req && we_i && sel_i;
      rd    = req && !we_i;
      pwm   = is_pwm(s_q.wgm);
      wword = {s_q.temp, dat_i};

      raw_in = s_q.cmp_sel ? comparator_output_i
                           : capture_input_pin_i;

      // port-driven pin takes the same path
      // single sample stage as the count pin
      if (!cap_is_top(s_q.wgm)) begin
         s_d.smp = raw_in;
         s_d.shf = {s_q.shf[2:0], s_q.smp};
      end

      // output moves only on four equal samples
      // filter on system clock, bit enabled
      if (s_q.filt_en) begin
         if (&s_q.shf)
            s_d.filt = 1'b1;
         else if (~|s_q.shf)
            s_d.filt = 1'b0;
         lvl = s_q.filt;
      end else begin
         s_d.filt = s_q.smp;
         lvl      = s_q.smp;
      end
      s_d.prev = lvl;

      cap_evt = s_q.edge_sel ? (lvl && !s_q.prev)
                             : (!lvl && s_q.prev);

      eq_a = (counter_value_i == s_q.ocr_a);
      eq_b = (counter_value_i == s_q.ocr_b);

      // write to counter blocks next tick
      hit_a = tick_i && eq_a && !s_q.block;
      hit_b = tick_i && eq_b && !s_q.block;
      // A stopped timer keeps the block armed until its next tick
      if (counter_wr_i)
         s_d.block = 1'b1;
      else if (tick_i)
         s_d.block = 1'b0;

      // Compare output state; never reset by mode
      // action bits used as they stand now
      // Action none leaves the state alone in every mode
      if (hit_a) begin
         if (!pwm)
            s_d.oc_a = apply(s_q.act_a, s_q.oc_a);
         else if (s_q.act_a[1])
            s_d.oc_a = s_q.act_a[0];
      end
      if (hit_b) begin
         if (!pwm)
            s_d.oc_b = apply(s_q.act_b, s_q.oc_b);
         else if (s_q.act_b[1])
            s_d.oc_b = s_q.act_b[0];
      end
      // PWM outputs return to the idle level at top
      if (pwm && tick_i && top_i) begin
         if (s_q.act_a[1])
            s_d.oc_a = ~s_q.act_a[0];
         if (s_q.act_b[1])
            s_d.oc_b = ~s_q.act_b[0];
      end

      // buffered values move to active at top or bottom
      upd = (s_q.wgm == WGM_PFC_CAP || s_q.wgm == WGM_PFC_A)
            ? bottom_i : top_i;
      if (pwm && tick_i && upd) begin
         s_d.ocr_a = s_q.buf_a;
         s_d.ocr_b = s_q.buf_b;
      end

      // flags cleared by acknowledge or by writing one
      // Clears act first so that a hardware set below wins
      s_d.flags = s_q.flags & ~irq_ack_i;
      if (wr && adr_i == OFF_FLAGS)
         s_d.flags = s_d.flags & ~dat_i[2:0];

      // Register writes
      if (wr) begin
         case (adr_i)
            OFF_CTRL_A: begin
               s_d.act_a = dat_i[1:0];
               s_d.act_b = dat_i[3:2];
            end
            OFF_CTRL_B: begin
               s_d.wgm      = dat_i[3:0];
               s_d.edge_sel = dat_i[B_EDGE];
               s_d.filt_en  = dat_i[B_FILT];
            end
            OFF_FORCE: begin
               // force applies action only, no flag
               if (!pwm && dat_i[0])
                  s_d.oc_a = apply(s_q.act_a, s_q.oc_a);
               if (!pwm && dat_i[1])
                  s_d.oc_b = apply(s_q.act_b, s_q.oc_b);
            end
            OFF_CMP_CS: s_d.cmp_sel = dat_i[0];
            OFF_IRQ_EN: s_d.irq_en  = dat_i[2:0];
            // high bytes go to the holding register
            OFF_CAP_HI, OFF_OCA_HI, OFF_OCB_HI:
               s_d.temp = dat_i;
            OFF_CAP_LO: begin
               if (cap_is_top(s_q.wgm))
                  s_d.cap = wword;
            end
            // low byte loads all sixteen bits
            OFF_OCA_LO: begin
               if (pwm)
                  s_d.buf_a = wword;
               else
                  s_d.ocr_a = wword;
            end
            OFF_OCB_LO: begin
               if (pwm)
                  s_d.buf_b = wword;
               else
                  s_d.ocr_b = wword;
            end
            default: ;
         endcase
      end

      if (cap_evt) begin
         s_d.cap        = counter_value_i;
         s_d.flags[F_CAP] = 1'b1;
      end
      // Set wins over any clear in the same cycle
      if (hit_a)
         s_d.flags[F_MA] = 1'b1;
      if (hit_b)
         s_d.flags[F_MB] = 1'b1;

      // Read data; compare reads return buffer bytes in PWM modes
      s_d.rdat = RST_BYTE;
      if (rd) begin
         case (adr_i)
            OFF_CTRL_A: s_d.rdat = {4'h0, s_q.act_b,
                                    s_q.act_a};
            OFF_CTRL_B: s_d.rdat = {2'b00, s_q.filt_en,
                                    s_q.edge_sel, s_q.wgm};
            OFF_CMP_CS: s_d.rdat = {7'h00, s_q.cmp_sel};
            OFF_FLAGS:  s_d.rdat = {5'h00, s_q.flags};
            OFF_IRQ_EN: s_d.rdat = {5'h00, s_q.irq_en};
            OFF_CAP_LO: begin
               s_d.rdat = s_q.cap[7:0];
               // low read latches the high byte
               s_d.temp = s_q.cap[15:8];
            end
            OFF_CAP_HI: s_d.rdat = s_q.temp;
            OFF_OCA_LO: s_d.rdat = pwm ? s_q.buf_a[7:0]
                                       : s_q.ocr_a[7:0];
            OFF_OCA_HI: s_d.rdat = pwm ? s_q.buf_a[15:8]
                                       : s_q.ocr_a[15:8];
            OFF_OCB_LO: s_d.rdat = pwm ? s_q.buf_b[7:0]
                                       : s_q.ocr_b[7:0];
            OFF_OCB_HI: s_d.rdat = pwm ? s_q.buf_b[15:8]
                                       : s_q.ocr_b[15:8];
            OFF_OUT_ST: s_d.rdat = {6'h00, s_q.oc_b,
                                    s_q.oc_a};
            default:    s_d.rdat = RST_BYTE;
         endcase
      end

      // Every access, mapped or not, is acked once
      s_d.ack = req;
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q.act_a    <= 2'b00;
         s_q.act_b    <= 2'b00;
         s_q.wgm      <= WGM_NORMAL;
         s_q.edge_sel <= 1'b0;
         s_q.filt_en  <= 1'b0;
         s_q.cmp_sel  <= 1'b0;
         s_q.flags    <= 3'b000;
         s_q.irq_en   <= 3'b000;
         s_q.temp     <= RST_BYTE;
         s_q.cap      <= RST_WORD;
         s_q.ocr_a    <= RST_WORD;
         s_q.ocr_b    <= RST_WORD;
         s_q.buf_a    <= RST_WORD;
         s_q.buf_b    <= RST_WORD;
         s_q.oc_a     <= 1'b0;
         s_q.oc_b     <= 1'b0;
         s_q.block    <= 1'b0;
         s_q.smp      <= 1'b0;
         s_q.shf      <= 4'h0;
         s_q.filt     <= 1'b0;
         s_q.prev     <= 1'b0;
         s_q.ack      <= 1'b0;
         s_q.rdat     <= RST_BYTE;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign dat_o = s_q.rdat;
   assign ack_o = s_q.ack;

   // request while flag and enable both set
   assign irq_o = s_q.flags & s_q.irq_en;

   assign compare_output_state_a_o = s_q.oc_a;
   assign compare_output_state_b_o = s_q.oc_b;
   assign waveform_mode_sel_o      = s_q.wgm;
   assign compare_value_a_o        = s_q.ocr_a;
   assign capture_value_o          = s_q.cap;

   // blocked match never reaches the counter top
   assign top_a_match_o = hit_a && a_is_top(s_q.wgm);

endmodule : tmr_cc

`default_nettype wire

// *** hw/tmr_cc_pkg.sv ***
// Constants for the timer capture and compare block.
// Assumes an 8-bit classic Wishbone slave port and one clock.
package tmr_cc_pkg;

   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [3:0] OFF_CTRL_A  = 4'h0;
   localparam logic [3:0] OFF_CTRL_B  = 4'h1;
   localparam logic [3:0] OFF_FORCE   = 4'h2;
   localparam logic [3:0] OFF_CMP_CS  = 4'h3;
   localparam logic [3:0] OFF_FLAGS   = 4'h4;
   localparam logic [3:0] OFF_IRQ_EN  = 4'h5;
   localparam logic [3:0] OFF_CAP_LO  = 4'h6;
   localparam logic [3:0] OFF_CAP_HI  = 4'h7;
   localparam logic [3:0] OFF_OCA_LO  = 4'h8;
   localparam logic [3:0] OFF_OCA_HI  = 4'h9;
   localparam logic [3:0] OFF_OCB_LO  = 4'hA;
   localparam logic [3:0] OFF_OCB_HI  = 4'hB;
   localparam logic [3:0] OFF_OUT_ST  = 4'hC;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int B_EDGE     = 4;
   localparam int B_FILT     = 5;
   localparam int F_CAP      = 0;
   localparam int F_MA       = 1;
   localparam int F_MB       = 2;
   localparam int FILT_TAPS  = 4;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;

   // ----------------------------------------
   // Waveform modes with special meaning
   // ----------------------------------------
   localparam logic [3:0] WGM_NORMAL  = 4'h0;
   localparam logic [3:0] WGM_CTC_A   = 4'h4;
   localparam logic [3:0] WGM_CTC_CAP = 4'hC;
   localparam logic [3:0] WGM_RSVD    = 4'hD;
   localparam logic [3:0] WGM_PFC_CAP = 4'h8;
   localparam logic [3:0] WGM_PFC_A   = 4'h9;

   // Compare output actions
   typedef enum logic [1:0] {
      ACT_NONE   = 2'b00,
      ACT_TOGGLE = 2'b01,
      ACT_CLEAR  = 2'b10,
      ACT_SET    = 2'b11
   } act_t;

endpackage : tmr_cc_pkg

// *** bench/tmr_cc_monitor.sv ***
// Concurrent checks on the ports of the capture and compare block.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module tmr_cc_monitor
   import tmr_cc_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic [3:0]  adr_i,
   input wire logic [7:0]  dat_i,
   input wire logic [7:0]  dat_o,
   input wire logic        we_i,
   input wire logic        sel_i,
   input wire logic        stb_i,
   input wire logic        cyc_i,
   input wire logic        ack_o,
   input wire logic        capture_input_pin_i,
   input wire logic        comparator_output_i,
   input wire logic [15:0] counter_value_i,
   input wire logic        counter_wr_i,
   input wire logic        tick_i,
   input wire logic        top_i,
   input wire logic        bottom_i,
   input wire logic [2:0]  irq_ack_i,
   input wire logic [2:0]  irq_o,
   input wire logic        compare_output_state_a_o,
   input wire logic        compare_output_state_b_o,
   input wire logic        top_a_match_o,
   input wire logic [3:0]  waveform_mode_sel_o,
   input wire logic [15:0] compare_value_a_o,
   input wire logic [15:0] capture_value_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic wr_taken;
   assign wr_taken = cyc_i && stb_i && we_i && sel_i && !ack_o;
   // ----------------------------------------
   // Bus and event relations
   // ----------------------------------------
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held too long");
   ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
   read_idle_a: assert property (!ack_o |-> dat_o == 8'h00) else $error("stray read data");
   cap_copy_a: assert property ($changed(capture_value_o) && !$past(wr_taken)
      |-> capture_value_o == $past(counter_value_i)) else $error("capture not counter");
   top_match_a: assert property (top_a_match_o
      |-> tick_i && counter_value_i == compare_value_a_o) else $error("bad top match");
   match_block_a: assert property (counter_wr_i ##1 tick_i |-> !top_a_match_o)
      else $error("match not blocked");
   out_cause_a: assert property ($changed(compare_output_state_a_o)
      |-> $past(tick_i || wr_taken)) else $error("output moved without cause");
   mode_write_a: assert property ($changed(waveform_mode_sel_o)
      |-> $past(wr_taken && adr_i == OFF_CTRL_B)) else $error("mode moved alone");
   cmp_cause_a: assert property ($changed(compare_value_a_o)
      |-> $past(tick_i || wr_taken)) else $error("compare value moved alone");
   mode_keep_out_a: assert property ($past(wr_taken && adr_i == OFF_CTRL_B && !tick_i)
      |-> $stable(compare_output_state_a_o)) else $error("output moved on mode write");
   cover property (top_a_match_o);
   cover property ($changed(capture_value_o));
   cover property ($rose(compare_output_state_a_o));
endmodule : tmr_cc_monitor
`default_nettype wire

// *** bench/count_model.sv ***
// Stand-in for the external 16-bit counter feeding the block.
// Assumes the bench drives tick and load just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module count_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        tick_i,
   input  wire logic        load_i,
   input  wire logic [15:0] load_val_i,
   input  wire logic [15:0] top_val_i,
   output logic      [15:0] cnt_o,
   output logic             wr_o,
   output logic             top_o,
   output logic             bottom_o
);
   // A CPU load beats counting, so the load pulse doubles as write strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_o <= 16'h0000;
      end else if (load_i) begin
         cnt_o <= load_val_i;
      end else if (tick_i) begin
         cnt_o <= cnt_o + 16'h0001;
      end
   end
   assign wr_o     = load_i;
   assign top_o    = (cnt_o == top_val_i);
   assign bottom_o = (cnt_o == 16'h0000);
endmodule : count_model
`default_nettype wire

// *** bench/tb_timer16_capture_compare.sv ***
// Self-checking bench for the capture and compare block.
// Assumes the counter model beside the block and the bound monitor.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin err_total++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_timer16_capture_compare
   import tmr_cc_pkg::*;
;
   logic clk_i = 1'h0, rst_i = 1'h1, we_i = 1'h0, sel_i = 1'h0, stb_i = 1'h0, cyc_i = 1'h0;
   logic capture_input_pin_i = 1'h0, comparator_output_i = 1'h0, tick_i = 1'h0, ld = 1'h0;
   logic [3:0]  adr_i = 4'h0;
   logic [7:0]  dat_i = 8'h00;
   logic [2:0]  irq_ack_i = 3'h0;
   logic [15:0] ld_val = 16'h0000, top_val = 16'hFFFF;
   logic [7:0]  dat_o;
   logic [2:0]  irq_o;
   logic [3:0]  waveform_mode_sel_o;
   logic [15:0] counter_value_i, compare_value_a_o, capture_value_o;
   logic ack_o, counter_wr_i, top_i, bottom_i, top_a_match_o;
   logic compare_output_state_a_o, compare_output_state_b_o;
   int   err_total = 0, total_checks = 0;
   always #2.5 clk_i = ~clk_i;
   count_model cm (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick_i), .load_i(ld),
      .load_val_i(ld_val), .top_val_i(top_val), .cnt_o(counter_value_i),
      .wr_o(counter_wr_i), .top_o(top_i), .bottom_o(bottom_i));
   tmr_cc uut (.*);
   // ----------------------------------------
   // Bus and stimulus helpers
   // ----------------------------------------
   task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
      int n;
      @(posedge clk_i);
      {adr_i, we_i, dat_i, sel_i, cyc_i, stb_i} <= {a, w, d, 3'h7};
      for (n = 0; n < 16; n++) begin
         @(posedge clk_i);
         if (ack_o === 1'h1) break;
      end
      q = dat_o;
      {we_i, sel_i, cyc_i, stb_i} <= 4'h0;
      if (n == 16) tally_and_finish(1'h1);
   endtask : bus
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(a, 1'h1, d, q);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] ex);
      logic [7:0] q;
      bus(a, 1'h0, 8'h00, q);
      `CHK("read data", ex, q)
   endtask : rd
   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask : idle
   // Load pulse followed at once by a tick, so the block window is exercised
   task automatic load_tick(input logic [15:0] v);
      @(posedge clk_i);
      ld_val <= v;
      ld     <= 1'h1;
      @(posedge clk_i);
      ld     <= 1'h0;
      tick_i <= 1'h1;
      @(posedge clk_i);
      tick_i <= 1'h0;
   endtask : load_tick
   task automatic tick();
      @(posedge clk_i);
      tick_i <= 1'h1;
      @(posedge clk_i);
      tick_i <= 1'h0;
   endtask : tick
   task automatic drive(input logic comp, input logic v);
      @(posedge clk_i);
      if (comp) comparator_output_i <= v;
      else capture_input_pin_i <= v;
      idle(10);
   endtask : drive
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_capture();
      `CHK("irq", 3'h0, irq_o)
      rd(4'hD, 8'h00);
      load_tick(16'h1233);
      wr(OFF_CTRL_B, 8'h10);
      drive(1'h0, 1'h1);
      rd(OFF_FLAGS, 8'h01);
      `CHK("cap value", 16'h1234, capture_value_o)
      load_tick(16'h5677);
      drive(1'h0, 1'h0);
      rd(OFF_CAP_LO, 8'h34);
      rd(OFF_CAP_HI, 8'h12);
      drive(1'h0, 1'h1);
      rd(OFF_CAP_LO, 8'h78);
      drive(1'h0, 1'h0);
      wr(OFF_CMP_CS, 8'h01);
      wr(OFF_FLAGS, 8'h01);
      drive(1'h0, 1'h1);
      rd(OFF_FLAGS, 8'h00);
      load_tick(16'h0ABB);
      drive(1'h1, 1'h1);
      rd(OFF_CAP_LO, 8'hBC);
      wr(OFF_CTRL_B, 8'h00);
      wr(OFF_FLAGS, 8'h01);
      drive(1'h1, 1'h0);
      rd(OFF_FLAGS, 8'h01);
      wr(OFF_CMP_CS, 8'h00);
   endtask : t_capture
   task automatic t_filter();
      wr(OFF_CTRL_B, 8'h30);
      drive(1'h0, 1'h0);
      wr(OFF_FLAGS, 8'h01);
      capture_input_pin_i <= 1'h1;
      idle(3);
      capture_input_pin_i <= 1'h0;
      idle(10);
      rd(OFF_FLAGS, 8'h00);
      drive(1'h0, 1'h1);
      rd(OFF_FLAGS, 8'h01);
      wr(OFF_CTRL_B, 8'h1C);
      drive(1'h0, 1'h0);
      wr(OFF_FLAGS, 8'h01);
      drive(1'h0, 1'h1);
      rd(OFF_FLAGS, 8'h00);
   endtask : t_filter
   task automatic t_compare();
      wr(OFF_CTRL_B, 8'h00);
      wr(OFF_OCA_HI, 8'h01);
      wr(OFF_OCA_LO, 8'h40);
      `CHK("cmp a", 16'h0140, compare_value_a_o)
      rd(OFF_OCA_HI, 8'h01);
      wr(OFF_IRQ_EN, 8'h02);
      load_tick(16'h0140);
      idle(2);
      `CHK("irq a", 1'h0, irq_o[1])
      load_tick(16'h013F);
      tick();
      idle(1);
      `CHK("irq a", 1'h1, irq_o[1])
      wr(OFF_FLAGS, 8'h02);
      `CHK("irq a", 1'h0, irq_o[1])
      load_tick(16'h013F);
      tick();
      irq_ack_i <= 3'h2;
      @(posedge clk_i);
      `CHK("irq a", 1'h1, irq_o[1])
      irq_ack_i <= 3'h0;
      idle(1);
      `CHK("irq a", 1'h0, irq_o[1])
   endtask : t_compare
   task automatic t_force_pwm();
      wr(OFF_CTRL_A, 8'h01);
      wr(OFF_FORCE, 8'h01);
      `CHK("out a", 1'h1, compare_output_state_a_o)
      wr(OFF_FORCE, 8'h01);
      `CHK("out a", 1'h0, compare_output_state_a_o)
      rd(OFF_FLAGS, 8'h00);
      wr(OFF_CTRL_A, 8'h03);
      wr(OFF_FORCE, 8'h01);
      `CHK("out a", 1'h1, compare_output_state_a_o)
      wr(OFF_CTRL_A, 8'h0F);
      wr(OFF_FORCE, 8'h02);
      `CHK("out b", 1'h1, compare_output_state_b_o)
      rd(OFF_OUT_ST, 8'h03);
      wr(OFF_CTRL_B, 8'h0F);
      `CHK("mode", 4'hF, waveform_mode_sel_o)
      `CHK("out a", 1'h1, compare_output_state_a_o)
      `CHK("out b", 1'h1, compare_output_state_b_o)
      top_val <= 16'h0140;
      wr(OFF_OCA_HI, 8'h00);
      wr(OFF_OCA_LO, 8'h20);
      `CHK("cmp a", 16'h0140, compare_value_a_o)
      rd(OFF_OCA_LO, 8'h20);
      load_tick(16'h013F);
      @(posedge clk_i);
      tick_i <= 1'h1;
      @(posedge clk_i);
      `CHK("top match", 1'h1, top_a_match_o)
      tick_i <= 1'h0;
      idle(1);
      `CHK("cmp a", 16'h0020, compare_value_a_o)
   endtask : t_force_pwm
   task automatic tally_and_finish(input logic hang);
      if (hang) err_total++;
      $display("Checks run %0d, errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      idle(16);
      rst_i <= 1'h0;
      t_capture();
      t_filter();
      t_compare();
      t_force_pwm();
      tally_and_finish(1'h0);
   end
endmodule : tb_timer16_capture_compare
bind tmr_cc tmr_cc_monitor mon (.*);
`default_nettype wire
